/* File: design/rotate_pkg.sv */
// Constants, types and layouts shared by the byte rotate unit
// Summary of operation
// - Left rotate no carry: bit7 wraps, carry untouched
// - Opcode 0100 01da; updates negative, zero only
// - Right through carry: bit0 to carry, carry in
// - Opcode 0011 00da; updates carry, negative, zero
// - Destination 0 writes working reg, 1 file
// - Bank bit 0 access bank, 1 bank register
// - Extended set, access, f<=95: indexed literal offset
// - File field 0..255, one-bit d and a
// - Left through carry: opcode 0011 01da, C,N,Z
package rotate_pkg;

	// Opcode field, instruction bits 15..10
	localparam logic [5:0] OPC_RLNC = 6'h11;
	localparam logic [5:0] OPC_RRC  = 6'h0C;
	localparam logic [5:0] OPC_RLC  = 6'h0D;

	// Instruction field positions
	localparam int OPC_MSB  = 15;
	localparam int OPC_LSB  = 10;
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam int FILE_MSB = 7;

	// Data memory addressing
	localparam int             ADDR_W         = 12;
	localparam logic [7:0]     ACCESS_SPLIT   = 8'h60;
	localparam logic [7:0]     INDEXED_MAX    = 8'h5F;
	localparam logic [3:0]     ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0]     ACCESS_HI_BANK = 4'hF;

	// Status register bit positions
	localparam int ST_CARRY = 0;
	localparam int ST_ZERO  = 2;
	localparam int ST_NEG   = 4;

	// Config register bit positions
	localparam int CFG_EXT = 0;

	// Software register offsets
	localparam logic [2:0] OFS_WORK   = 3'h0;
	localparam logic [2:0] OFS_STATUS = 3'h1;
	localparam logic [2:0] OFS_BANK   = 3'h2;
	localparam logic [2:0] OFS_CONFIG = 3'h3;

	// Reset values
	localparam logic [7:0] RST_WORK   = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [3:0] RST_BANK   = 4'h0;
	localparam logic       RST_EXT    = 1'b0;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_RLNC,
		OP_RRC,
		OP_RLC
	} rot_op_t;

	typedef struct packed {
		rot_op_t    op;
		logic       dest_file;
		logic       bank_sel;
		logic [7:0] file;
	} rot_insn_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              rd;
		logic              wr;
		logic [7:0]        wdata;
	} mem_req_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage

/* File: design/byte_rotate_unit.sv */
// Byte rotate datapath: decode, operand fetch, rotate, write-back
module byte_rotate_unit
	import rotate_pkg::*;
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	// Instruction from decoder
	input  wire logic                       insn_valid,
	input  wire logic [15:0]                insn_word,
	input  wire logic [rotate_pkg::ADDR_W-1:0] index_base,
	output logic                            insn_ready,
	output logic                            insn_done,
	output logic                            insn_unsupported,
	// Data memory register file
	output rotate_pkg::mem_req_t            mem_req,
	input  wire logic [7:0]                 mem_rdata,
	// Software register port
	input  wire rotate_pkg::reg_req_t       reg_req,
	output logic [7:0]                      reg_rdata,
	// Core state views
	output logic [7:0]                      work_value,
	output logic [7:0]                      status_value
);
	import rotate_pkg::*;

	typedef enum logic [1:0] {
		PH_DECODE,
		PH_READ,
		PH_PROCESS,
		PH_WRITE
	} phase_t;

	logic              rst_meta_ff;
	logic              rst_sync_ff;
	phase_t            phase_ff;
	rot_insn_t         insn_ff;
	rot_insn_t         nxt_insn;
	mem_req_t          mem_ff;
	logic [ADDR_W-1:0] nxt_addr;
	logic [7:0]        nxt_result;
	logic              nxt_carry;
	logic [7:0]        work_ff;
	logic [7:0]        status_ff;
	logic [3:0]        bank_ff;
	logic              ext_ff;
	logic [7:0]        rdata_ff;
	logic              ready_ff;
	logic              done_ff;
	logic              unsup_ff;
	logic              take;
	logic              retire;

	// Reset release through two flops so every other flop leaves reset together
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Decode of the incoming word
	always_comb begin
		nxt_insn.dest_file = insn_word[DEST_BIT];
		nxt_insn.bank_sel  = insn_word[BANK_BIT];
		nxt_insn.file      = insn_word[FILE_MSB:0];
		unique case (insn_word[OPC_MSB:OPC_LSB])
			OPC_RLNC: nxt_insn.op = OP_RLNC;
			OPC_RRC:  nxt_insn.op = OP_RRC;
			OPC_RLC:  nxt_insn.op = OP_RLC;
			default:  nxt_insn.op = OP_NONE;
		endcase
	end

	// Operand address from bank bit, bank register and extended mode
	always_comb begin
		if (nxt_insn.bank_sel) begin
			nxt_addr = {bank_ff, nxt_insn.file};
		end else if (ext_ff && nxt_insn.file <= INDEXED_MAX) begin
			nxt_addr = ADDR_W'(index_base + {4'h0, nxt_insn.file});
		end else if (nxt_insn.file < ACCESS_SPLIT) begin
			nxt_addr = {ACCESS_LO_BANK, nxt_insn.file};
		end else begin
			nxt_addr = {ACCESS_HI_BANK, nxt_insn.file};
		end
	end

	// Rotate on the fetched operand
	always_comb begin
		nxt_carry = status_ff[ST_CARRY];
		unique case (insn_ff.op)
			OP_RLNC: begin
				nxt_result = {mem_rdata[6:0], mem_rdata[7]};
			end
			OP_RRC: begin
				nxt_result = {status_ff[ST_CARRY], mem_rdata[7:1]};
				nxt_carry  = mem_rdata[0];
			end
			OP_RLC: begin
				nxt_result = {mem_rdata[6:0], status_ff[ST_CARRY]};
				nxt_carry  = mem_rdata[7];
			end
			OP_NONE: begin
				nxt_result = mem_rdata;
			end
		endcase
	end

	assign take   = ce && phase_ff == PH_DECODE && insn_valid;
	assign retire = ce && phase_ff == PH_PROCESS;

	// Four phases per supported instruction, one per clock
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			phase_ff <= PH_DECODE;
		end else if (ce) begin
			unique case (phase_ff)
				PH_DECODE: begin
					if (insn_valid && nxt_insn.op != OP_NONE) begin
						phase_ff <= PH_READ;
					end
				end
				PH_READ:    phase_ff <= PH_PROCESS;
				PH_PROCESS: phase_ff <= PH_WRITE;
				PH_WRITE:   phase_ff <= PH_DECODE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			insn_ff <= '0;
		end else if (take) begin
			insn_ff <= nxt_insn;
		end
	end

	// Handshake flags toward the decoder
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			ready_ff <= 1'b0;
			done_ff  <= 1'b0;
			unsup_ff <= 1'b0;
		end else if (ce) begin
			ready_ff <= (phase_ff == PH_DECODE && !(insn_valid && nxt_insn.op != OP_NONE))
				|| phase_ff == PH_WRITE;
			done_ff  <= phase_ff == PH_PROCESS;
			unsup_ff <= take && nxt_insn.op == OP_NONE;
		end
	end

	// Memory read issued after decode, write only for file destination
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			mem_ff <= '0;
		end else if (ce) begin
			mem_ff.rd <= take && nxt_insn.op != OP_NONE;
			mem_ff.wr <= retire && insn_ff.dest_file;
			if (take) begin
				mem_ff.addr <= nxt_addr;
			end
			if (retire) begin
				mem_ff.wdata <= nxt_result;
			end
		end
	end

	// Working register: instruction result beats a same-cycle software write
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			work_ff <= RST_WORK;
		end else if (retire && !insn_ff.dest_file) begin
			work_ff <= nxt_result;
		end else if (ce && reg_req.wr && reg_req.addr == OFS_WORK) begin
			work_ff <= reg_req.wdata;
		end
	end

	// Flags: hardware update wins over a software write in the same cycle
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			status_ff <= RST_STATUS;
		end else if (retire) begin
			status_ff[ST_ZERO] <= nxt_result == 8'h00;
			status_ff[ST_NEG]  <= nxt_result[7];
			if (insn_ff.op != OP_RLNC) begin
				status_ff[ST_CARRY] <= nxt_carry;
			end
		end else if (ce && reg_req.wr && reg_req.addr == OFS_STATUS) begin
			status_ff <= reg_req.wdata;
		end
	end

	// Bank register and extended set enable
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			bank_ff <= RST_BANK;
			ext_ff  <= RST_EXT;
		end else if (ce && reg_req.wr) begin
			if (reg_req.addr == OFS_BANK) begin
				bank_ff <= reg_req.wdata[3:0];
			end
			if (reg_req.addr == OFS_CONFIG) begin
				ext_ff <= reg_req.wdata[CFG_EXT];
			end
		end
	end

	// Read data valid in the cycle after the strobe only
	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			rdata_ff <= 8'h00;
		end else if (ce) begin
			rdata_ff <= 8'h00;
			if (reg_req.rd) begin
				unique case (reg_req.addr)
					OFS_WORK:   rdata_ff <= work_ff;
					OFS_STATUS: rdata_ff <= status_ff;
					OFS_BANK:   rdata_ff <= {4'h0, bank_ff};
					OFS_CONFIG: rdata_ff <= {7'h00, ext_ff};
					default:    rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	assign insn_ready       = ready_ff;
	assign insn_done        = done_ff;
	assign insn_unsupported = unsup_ff;
	assign mem_req          = mem_ff;
	assign reg_rdata        = rdata_ff;
	assign work_value       = work_ff;
	assign status_value     = status_ff;

endmodule

/* File: verification/reg_file_model.sv */
// Data memory register file behind the rotate unit
module reg_file_model
	import rotate_pkg::*;
(
	// Clock
	input  wire logic                 clk,
	// Request and answer
	input  wire rotate_pkg::mem_req_t mem_req,
	output logic [7:0]                mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [4096];
	initial mem_rdata = 8'h00;
	// Inverted each idle cycle so a sample one cycle late never matches
	always @(posedge clk) begin
		mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
		if (mem_req.wr)
			mem[mem_req.addr] <= mem_req.wdata;
	end
endmodule

/* File: verification/byte_rotate_unit_asserts.sv */
// Port checks for the byte rotate unit
module byte_rotate_unit_asserts
	import rotate_pkg::*;
(
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst_n,
	// Observed ports
	input wire logic [15:0]          insn_word,
	input wire logic                 insn_done,
	input wire rotate_pkg::mem_req_t mem_req,
	input wire logic [7:0]           mem_rdata,
	input wire logic [7:0]           work_value,
	input wire logic [7:0]           status_value
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [47:0] sh_ff;
	logic [7:0]  res;
	logic [5:0]  op;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Taken word reaches the top slice at retire
	always_ff @(posedge clk)
		sh_ff <= {sh_ff[31:0], insn_word};
	assign op = sh_ff[47:42];
	assign res = sh_ff[41] ? mem_req.wdata : work_value;
	a_rd_pulse: assert property (mem_req.rd |=> !mem_req.rd)
		else $error("read strobe too long");
	a_done_delay: assert property (mem_req.rd |-> ##2 insn_done)
		else $error("retire not two after read");
	a_file_dest: assert property (insn_done && sh_ff[41] |-> mem_req.wr && $stable(work_value))
		else $error("file destination wrong");
	a_wr_cause: assert property (mem_req.wr |-> insn_done && sh_ff[41])
		else $error("stray file write");
	a_left_nc: assert property (insn_done && op == OPC_RLNC |->
		res == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(status_value[ST_CARRY]))
		else $error("left rotate no carry wrong");
	a_right_c: assert property (insn_done && op == OPC_RRC |->
		res == {$past(status_value[ST_CARRY]), $past(mem_rdata[7:1])}
		&& status_value[ST_CARRY] == $past(mem_rdata[0]))
		else $error("right rotate carry wrong");
	a_left_c: assert property (insn_done && op == OPC_RLC |->
		res == {$past(mem_rdata[6:0]), $past(status_value[ST_CARRY])}
		&& status_value[ST_CARRY] == $past(mem_rdata[7]))
		else $error("left rotate carry wrong");
	a_flags_nz: assert property (insn_done |->
		status_value[ST_ZERO] == (res == 8'h00) && status_value[ST_NEG] == res[7])
		else $error("zero or negative flag wrong");
endmodule
bind byte_rotate_unit byte_rotate_unit_asserts chk (.clk, .rst_n, .insn_word, .insn_done,
	.mem_req, .mem_rdata, .work_value, .status_value);

/* File: verification/byte_rotate_unit_tb.sv */
// Self-checking bench for the byte rotate unit
module byte_rotate_unit_tb;
	import rotate_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;
	logic        rst_n;
	logic        insn_valid;
	logic        insn_ready;
	logic        insn_done;
	logic        insn_unsup;
	logic        ce;
	logic [15:0] insn_word;
	logic [7:0]  mem_rdata;
	logic [7:0]  reg_rdata;
	logic [7:0]  work_value;
	logic [7:0]  status_value;
	mem_req_t    mem_req;
	reg_req_t    rq;
	int          fails;
	int          num_checks;
	int          cyc;
	byte_rotate_unit dut (.clk, .rst_n, .ce(ce), .insn_valid, .insn_word,
		.index_base(12'hFF0), .insn_ready, .insn_done, .insn_unsupported(insn_unsup),
		.mem_req, .mem_rdata, .reg_req(rq), .reg_rdata, .work_value, .status_value);
	reg_file_model fm (.clk, .mem_req, .mem_rdata);
	task automatic close_out;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [11:0] e, logic [11:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic reg_wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk) rq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) rq <= '0;
	endtask
	task automatic reg_rd(logic [2:0] a, logic [7:0] e);
		@(posedge clk) rq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) rq <= '0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	// Retires one word; stays back to back when called in a row
	task automatic exec(logic [15:0] w, logic [11:0] a, logic [7:0] v, r, s);
		fm.mem[a] = v;
		@(posedge clk) insn_valid <= 1'b1;
		insn_word <= w;
		for (int i = 0; i < 9 && insn_ready !== 1'b1; i++)
			@(negedge clk);
		@(posedge clk) insn_valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("done", 1, insn_done);
		chk("addr", a, mem_req.addr);
		chk("status", s, status_value);
		chk(w[9] ? "wdata" : "work", r, w[9] ? mem_req.wdata : work_value);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 4; i++)
			reg_rd(i[2:0], 8'h00);
		reg_wr(3'h5, 8'hFF);
		reg_rd(3'h5, 8'h00);
		reg_wr(OFS_WORK, 8'h3C);
		reg_rd(OFS_WORK, 8'h3C);
		@(posedge clk) #1 chk("reg_rdata idle", 8'h00, reg_rdata);
	endtask
	// Clock enable low must hold the working register against a software write
	task automatic t_freeze;
		@(posedge clk) ce <= 1'b0;
		rq <= '{OFS_WORK, 8'h5A, 1'b1, 1'b0};
		@(posedge clk) rq <= '0;
		@(posedge clk) ce <= 1'b1;
		#1 chk("work frozen", 8'h3C, work_value);
	endtask
	// Unknown opcode is consumed with a one-cycle flag and no memory access
	task automatic t_unsup;
		@(posedge clk) insn_valid <= 1'b1;
		insn_word <= 16'hFC00;
		@(posedge clk) insn_valid <= 1'b0;
		#1 chk("unsupported", 1, insn_unsup);
		chk("rd", 0, mem_req.rd);
		@(posedge clk) #1 chk("unsupported", 0, insn_unsup);
		chk("done", 0, insn_done);
	endtask
	task automatic t_rlnc;
		reg_wr(OFS_STATUS, 8'h01);
		exec({OPC_RLNC, 10'h220}, 12'h020, 8'hAB, 8'h57, 8'h01);
		exec({OPC_RLNC, 10'h07F}, 12'hF7F, 8'h80, 8'h01, 8'h01);
		exec({OPC_RLNC, 10'h000}, 12'h000, 8'h00, 8'h00, 8'h05);
	endtask
	task automatic t_rrc;
		reg_wr(OFS_STATUS, 8'h00);
		exec({OPC_RRC, 10'h010}, 12'h010, 8'hE6, 8'h73, 8'h00);
		exec({OPC_RRC, 10'h211}, 12'h011, 8'h01, 8'h00, 8'h05);
		exec({OPC_RRC, 10'h012}, 12'h012, 8'h00, 8'h80, 8'h10);
	endtask
	task automatic t_rlc;
		exec({OPC_RLC, 10'h030}, 12'h030, 8'hE6, 8'hCC, 8'h11);
	endtask
	task automatic t_bank;
		reg_wr(OFS_BANK, 8'h05);
		reg_rd(OFS_BANK, 8'h05);
		exec({OPC_RLNC, 10'h3FF}, 12'h5FF, 8'h01, 8'h02, 8'h01);
		exec({OPC_RLNC, 10'h060}, 12'hF60, 8'h02, 8'h04, 8'h01);
		reg_rd(OFS_WORK, 8'h04);
		reg_rd(OFS_STATUS, 8'h01);
	endtask
	task automatic t_indexed;
		reg_wr(OFS_CONFIG, 8'h01);
		reg_rd(OFS_CONFIG, 8'h01);
		exec({OPC_RLNC, 10'h05F}, 12'h04F, 8'h04, 8'h08, 8'h01);
		exec({OPC_RLNC, 10'h260}, 12'hF60, 8'h40, 8'h80, 8'h11);
		exec({OPC_RLNC, 10'h100}, 12'h500, 8'h81, 8'h03, 8'h01);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Whole run needs about a hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		rst_n = 1'b0;
		insn_valid = 1'b0;
		ce = 1'b1;
		insn_word = 16'h0000;
		rq = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_freeze();
		t_unsup();
		t_rlnc();
		t_rrc();
		t_rlc();
		t_bank();
		t_indexed();
		close_out();
	end
endmodule
